// File: crf_fifo.v
// Configurable RAM FIFO with single or dual clock operation, status flags,
// sticky event register with mask and one level interrupt.
// Assumes the writer runs on core_clk, the reader on rd_clk in dual clock
// mode (core_clk otherwise), and software on core_clk.
`timescale 1ns/1ps
`include "crf_defines.vh"

module crf_fifo #(
  parameter DATA_W = `CRF_DATA_W,
  parameter DEPTH = `CRF_DEPTH,
  parameter AFULL_OFFSET = `CRF_AFULL_OFFSET,
  parameter AEMPTY_OFFSET = `CRF_AEMPTY_OFFSET,
  parameter DUAL_CLOCK = 0,
  parameter FWFT = 0,
  parameter SYNC_RESET = 0,
  parameter PROTECT = 1,
  parameter OUT_HOLD = 1
) (
  input wire core_clk, // Write side and register clock
  input wire reset, // Asynchronous reset, active high
  input wire rd_clk, // Read clock, used in dual clock mode only
  input wire wr_en, // Write request
  input wire [DATA_W-1:0] wr_data, // Write data
  output wire full, // Stored words equal depth
  output wire almost_full, // Near-full flag
  input wire rd_en, // Read request
  output wire [DATA_W-1:0] rd_data, // Read data, from a register
  output wire empty, // No word available to read
  output wire almost_empty, // Near-empty flag
  input wire [3:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [31:0] reg_rdata_r, // Register read data, cycle after strobe
  output wire irq // Level interrupt
);

  // DEPTH must be a power of two; pointers carry one bit above the address
  // so that a full buffer and an empty one give different differences
  localparam AW = $clog2(DEPTH);
  localparam [AW:0] DEPTH_C = DEPTH[AW:0];
  localparam integer AFULL_INT = DEPTH - AFULL_OFFSET;
  localparam [AW:0] AFULL_LVL = AFULL_INT[AW:0];
  localparam [AW:0] AEMPTY_LVL = AEMPTY_OFFSET[AW:0];

  // Gray conversion of pointers, used on both sides of the crossing
  function [AW:0] bin2gray;
    input [AW:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [AW:0] gray2bin;
    input [AW:0] g;
    integer i;
    begin
      gray2bin[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // Pointer step by zero or one, kept at pointer width so no carry is lost
  function [AW:0] ptr_step;
    input [AW:0] p;
    input inc;
    begin
      ptr_step = p + {{AW{1'b0}}, inc};
    end
  endfunction

  // Words between two pointers; wraps cleanly thanks to the extra top bit
  function [AW:0] ptr_diff;
    input [AW:0] head;
    input [AW:0] tail;
    begin
      ptr_diff = head - tail;
    end
  endfunction

  // Read side clock selection is fixed at build time
  wire rclk;
  generate
    if (DUAL_CLOCK) begin : g_rclk_dual
      assign rclk = rd_clk;
    end else begin : g_rclk_single
      assign rclk = core_clk;
    end
  endgenerate

  // Reset release synchronisers; assertion stays asynchronous
  reg [`CRF_SYNC_STAGES-1:0] wrst_sync_r;
  reg [`CRF_SYNC_STAGES-1:0] rrst_sync_r;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrst_sync_r <= {`CRF_SYNC_STAGES{1'b1}};
    end else begin
      wrst_sync_r <= {wrst_sync_r[`CRF_SYNC_STAGES-2:0], 1'b0};
    end
  end

  always @(posedge rclk or posedge reset) begin
    if (reset) begin
      rrst_sync_r <= {`CRF_SYNC_STAGES{1'b1}};
    end else begin
      rrst_sync_r <= {rrst_sync_r[`CRF_SYNC_STAGES-2:0], 1'b0};
    end
  end

  // Synchronous reset option trusts the user to time reset to both clocks
  wire wrst = SYNC_RESET ? reset : wrst_sync_r[`CRF_SYNC_STAGES-1];
  wire rrst = SYNC_RESET ? reset : rrst_sync_r[`CRF_SYNC_STAGES-1];

  reg [AW:0] wptr_r;
  reg [AW:0] rptr_r;
  reg [AW:0] wgray_r;
  reg [AW:0] rgray_r;
  wire [AW:0] rptr_at_w;
  wire [AW:0] wptr_at_r;

  // Pointer crossing: gray code through two flops, or direct in single mode
  generate
    if (DUAL_CLOCK) begin : g_cross
      reg [AW:0] rg_s1_r;
      reg [AW:0] rg_s2_r;
      reg [AW:0] wg_s1_r;
      reg [AW:0] wg_s2_r;
      always @(posedge core_clk or posedge wrst) begin
        if (wrst) begin
          rg_s1_r <= {(AW+1){1'b0}};
          rg_s2_r <= {(AW+1){1'b0}};
        end else begin
          rg_s1_r <= rgray_r;
          rg_s2_r <= rg_s1_r;
        end
      end
      always @(posedge rclk or posedge rrst) begin
        if (rrst) begin
          wg_s1_r <= {(AW+1){1'b0}};
          wg_s2_r <= {(AW+1){1'b0}};
        end else begin
          wg_s1_r <= wgray_r;
          wg_s2_r <= wg_s1_r;
        end
      end
      assign rptr_at_w = gray2bin(rg_s2_r);
      assign wptr_at_r = gray2bin(wg_s2_r);
    end else begin : g_direct
      assign rptr_at_w = rptr_r;
      assign wptr_at_r = wptr_r;
    end
  endgenerate

  // Write side occupancy and flags
  wire [AW:0] wcount = ptr_diff(wptr_r, rptr_at_w);
  assign full = (wcount == DEPTH_C);
  assign almost_full = (wcount >= AFULL_LVL);
  // Unprotected builds pass the request straight through for speed
  wire wr_go = wr_en & (~full | (PROTECT == 0));
  // Overflow is flagged in every build so software learns of a lost word
  wire wr_over = wr_en & full;

  always @(posedge core_clk or posedge wrst) begin
    if (wrst) begin
      wptr_r <= {(AW+1){1'b0}};
      wgray_r <= {(AW+1){1'b0}};
    end else begin
      if (wr_go) begin
        wptr_r <= ptr_step(wptr_r, 1'b1);
      end
      wgray_r <= bin2gray(ptr_step(wptr_r, wr_go));
    end
  end

  // Read side occupancy of the RAM itself
  wire [AW:0] rcount = ptr_diff(wptr_at_r, rptr_r);
  wire ram_empty = (rcount == {(AW+1){1'b0}});
  assign almost_empty = (rcount < AEMPTY_LVL);

  reg out_vld_r;
  wire ram_re;
  wire rd_under;

  // Fall-through prefetches into the output register; standard waits for rd_en
  generate
    if (FWFT) begin : g_fwft
      assign ram_re = ~ram_empty & (~out_vld_r | rd_en);
      assign rd_under = rd_en & ~out_vld_r;
      assign empty = ~out_vld_r;
    end else begin : g_std
      assign ram_re = rd_en & (~ram_empty | (PROTECT == 0));
      assign rd_under = rd_en & ram_empty;
      assign empty = ram_empty;
    end
  endgenerate

  always @(posedge rclk or posedge rrst) begin
    if (rrst) begin
      rptr_r <= {(AW+1){1'b0}};
      rgray_r <= {(AW+1){1'b0}};
      out_vld_r <= 1'b0;
    end else begin
      if (ram_re) begin
        rptr_r <= ptr_step(rptr_r, 1'b1);
      end
      rgray_r <= bin2gray(ptr_step(rptr_r, ram_re));
      if (ram_re) begin
        out_vld_r <= 1'b1;
      end else if (rd_en) begin
        out_vld_r <= 1'b0;
      end
    end
  end

  // Without hold the read register reloads every cycle, so a word lasts one
  // cycle; fall-through needs the word parked, so it always holds.
  wire ram_load = ram_re | ((OUT_HOLD == 0) & (FWFT == 0));

  crf_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(AW)
  ) u_ram (
    .wr_clk(core_clk),
    .wr_en(wr_go),
    .wr_addr(wptr_r[AW-1:0]),
    .wr_data(wr_data),
    .rd_clk(rclk),
    .rd_rst(rrst),
    .rd_en(ram_load),
    .rd_addr(rptr_r[AW-1:0]),
    .rd_data_r(rd_data)
  );

  // Underflow event crosses to core_clk as a toggle; a one-cycle pulse
  // could fall between two edges of an unrelated clock and be lost
  reg uf_tgl_r;
  always @(posedge rclk or posedge rrst) begin
    if (rrst) begin
      uf_tgl_r <= 1'b0;
    end else if (rd_under) begin
      uf_tgl_r <= ~uf_tgl_r;
    end
  end

  reg [2:0] uf_sync_r;
  always @(posedge core_clk or posedge wrst) begin
    if (wrst) begin
      uf_sync_r <= 3'h0;
    end else begin
      uf_sync_r <= {uf_sync_r[1:0], uf_tgl_r};
    end
  end
  wire ev_under = uf_sync_r[2] ^ uf_sync_r[1];

  // Edge detect of write side flags for the event register
  reg full_d_r;
  reg afull_d_r;
  always @(posedge core_clk or posedge wrst) begin
    if (wrst) begin
      full_d_r <= 1'b0;
      afull_d_r <= 1'b0;
    end else begin
      full_d_r <= full;
      afull_d_r <= almost_full;
    end
  end

  wire [`CRF_EV_W-1:0] ev;
  assign ev[`CRF_EV_OVERFLOW] = wr_over;
  assign ev[`CRF_EV_UNDERFLOW] = ev_under;
  assign ev[`CRF_EV_FULL] = full & ~full_d_r;
  assign ev[`CRF_EV_AFULL] = almost_full & ~afull_d_r;

  // Status is write-one-to-clear; a new event in the same cycle wins
  reg [`CRF_EV_W-1:0] sts_r;
  reg [`CRF_EV_W-1:0] mask_r;
  wire sts_wr = reg_wr & (reg_addr == `CRF_REG_STATUS);
  wire mask_wr = reg_wr & (reg_addr == `CRF_REG_MASK);
  wire [`CRF_EV_W-1:0] sts_nxt = (sts_r & ~({`CRF_EV_W{sts_wr}} & reg_wdata[`CRF_EV_W-1:0])) | ev;

  always @(posedge core_clk or posedge wrst) begin
    if (wrst) begin
      sts_r <= `CRF_STATUS_RST;
      mask_r <= `CRF_MASK_RST;
    end else begin
      sts_r <= sts_nxt;
      if (mask_wr) begin
        mask_r <= reg_wdata[`CRF_EV_W-1:0];
      end
    end
  end

  // Level output; stays high until software clears the status bit or masks it
  assign irq = |(sts_r & mask_r);

  // Read data: stand for the cycle after the strobe only, zero otherwise
  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `CRF_REG_STATUS: rdata_nxt[`CRF_EV_W-1:0] = sts_r;
        `CRF_REG_MASK: rdata_nxt[`CRF_EV_W-1:0] = mask_r;
        `CRF_REG_LEVEL: begin
          rdata_nxt[`CRF_LVL_FULL] = full;
          rdata_nxt[`CRF_LVL_AFULL] = almost_full;
          rdata_nxt[`CRF_LVL_COUNT_LSB +: AW+1] = wcount;
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always @(posedge core_clk or posedge wrst) begin
    if (wrst) begin
      reg_rdata_r <= 32'h0;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule // crf_fifo

// File: crf_defines.vh
// Constants of the configurable RAM FIFO: register offsets, field positions,
// reset values and build-option defaults.
// Assumes inclusion by bare name from the FIFO design files.
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// Register word offsets on the software port (byte addresses)
`define CRF_REG_STATUS 4'h0
`define CRF_REG_MASK 4'h4
`define CRF_REG_LEVEL 4'h8

// Sticky event bits of status and mask
`define CRF_EV_W 4
`define CRF_EV_OVERFLOW 0
`define CRF_EV_UNDERFLOW 1
`define CRF_EV_FULL 2
`define CRF_EV_AFULL 3

// Level register fields
`define CRF_LVL_FULL 0
`define CRF_LVL_AFULL 1
`define CRF_LVL_COUNT_LSB 4

// Reset values
`define CRF_STATUS_RST 4'h0
`define CRF_MASK_RST 4'h0

// Build-option defaults
`define CRF_DATA_W 32
`define CRF_DEPTH 512
`define CRF_AFULL_OFFSET 4
`define CRF_AEMPTY_OFFSET 4

// Synchroniser length for reset release; the pointer crossing uses two fixed flops
`define CRF_SYNC_STAGES 2

`endif

// File: crf_ram.v
// Simple two-port RAM for the FIFO: one write port, one registered read port.
// Assumes the write and read clocks may be unrelated; read data only change
// on a cycle with the read enable high, so holding them is the caller's choice.
`timescale 1ns/1ps

module crf_ram #(
  parameter DATA_W = 32,
  parameter ADDR_W = 9
) (
  input wire wr_clk, // Write clock
  input wire wr_en, // Write this cycle
  input wire [ADDR_W-1:0] wr_addr, // Write address
  input wire [DATA_W-1:0] wr_data, // Write data
  input wire rd_clk, // Read clock
  input wire rd_rst, // Async clear of the read register
  input wire rd_en, // Load the read register
  input wire [ADDR_W-1:0] rd_addr, // Read address
  output reg [DATA_W-1:0] rd_data_r // Registered read data
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Storage array has no reset; contents can be read before being written only in standard read builds that lack either hold or protection
  always @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read register; cleared on reset so the output is defined from the start
  always @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rd_data_r <= {DATA_W{1'b0}};
    end else if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule // crf_ram

// File: crf_user.sv
// User-side model: writer and reader of the FIFO data ports.
// Assumes one shared clock; drives by non-blocking assignment after rising edges.
`timescale 1ns/1ps
module crf_user #(
  parameter DATA_W = 8
) (
  input wire core_clk, // Shared clock
  output reg wr_en, // Write request
  output reg [DATA_W-1:0] wr_data, // Write data
  output reg rd_en, // Read request
  input wire [DATA_W-1:0] rd_data // Read data
);
  initial begin
    wr_en = 1'h0;
    wr_data = '0;
    rd_en = 1'h0;
  end
  // Back-to-back writes; idle data inverted so a stale word never matches
  task burst(input integer n, input [DATA_W-1:0] base);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk);
        wr_en <= 1'h1;
        wr_data <= base + i[DATA_W-1:0];
      end
      @(posedge core_clk);
      wr_en <= 1'h0;
      wr_data <= ~wr_data;
    end
  endtask
  // One read; the word is taken in the one cycle it is sure to stand
  task pop(output [DATA_W-1:0] d);
    begin
      @(posedge core_clk);
      rd_en <= 1'h1;
      @(posedge core_clk);
      rd_en <= 1'h0;
      #1 d = rd_data;
    end
  endtask
endmodule // crf_user

// File: crf_fifo_chk.sv
// Checker of the FIFO ports in single clock, standard read mode.
// Assumes rd_clk equals core_clk; keeps its own mirror of stored words.
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_fifo_chk #(
  parameter DATA_W = 8,
  parameter DEPTH = 8,
  parameter AFULL_OFFSET = 2,
  parameter AEMPTY_OFFSET = 2,
  parameter DUAL_CLOCK = 0,
  parameter FWFT = 0
) (
  input wire core_clk, // Clock
  input wire reset, // Reset
  input wire rd_clk, // Read clock
  input wire wr_en, // Write request
  input wire [DATA_W-1:0] wr_data, // Write data
  input wire full, // Full flag
  input wire almost_full, // Near-full flag
  input wire rd_en, // Read request
  input wire [DATA_W-1:0] rd_data, // Read data
  input wire empty, // Empty flag
  input wire almost_empty, // Near-empty flag
  input wire [3:0] reg_addr, // Register address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write
  input wire reg_rd, // Register read
  input wire [31:0] reg_rdata_r, // Register read data
  input wire irq // Interrupt
);
  localparam AW = $clog2(DEPTH);
  reg [AW:0] cnt_r;
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [DATA_W-1:0] mem_r [0:DEPTH-1];
  wire wr_ok = wr_en && !full;
  wire rd_ok = rd_en && !empty;
  wire [DATA_W-1:0] head = mem_r[rp_r];
  // Mirror counts accepted requests only, so a refused one shows as a flag slip
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      cnt_r <= cnt_r + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
      wp_r <= wp_r + AW'(wr_ok);
      rp_r <= rp_r + AW'(rd_ok);
    end
  end
  // Mirror storage
  always @(posedge core_clk) begin
    if (wr_ok) mem_r[wp_r] <= wr_data;
  end
  default clocking cb @(posedge core_clk); endclocking
  // Dual clock and fall-through builds are watched by the bench alone
  default disable iff (reset || DUAL_CLOCK != 0 || FWFT != 0);
  AST_FULL: assert property (full == (cnt_r == DEPTH))
    else $error("full flag wrong");
  AST_EMPTY: assert property (empty == (cnt_r == 0))
    else $error("empty flag wrong");
  AST_AFULL: assert property (almost_full == (cnt_r >= DEPTH - AFULL_OFFSET))
    else $error("almost full wrong");
  AST_AEMPTY: assert property (almost_empty == (cnt_r < AEMPTY_OFFSET))
    else $error("almost empty wrong");
  AST_RDDATA: assert property (rd_ok |=> rd_data == $past(head))
    else $error("read word wrong");
  AST_HOLD: assert property (!rd_ok |=> $stable(rd_data))
    else $error("read data moved");
  AST_LEVEL: assert property (reg_rd && reg_addr == `CRF_REG_LEVEL
    |=> reg_rdata_r[1:0] == {$past(almost_full), $past(full)}) else $error("level wrong");
  AST_MASK: assert property (reg_wr && reg_addr == `CRF_REG_MASK && reg_wdata[3:0] == 4'h0
    |-> ##2 !irq) else $error("masked irq high");
  COV_OVF: cover property (wr_en && full);
  COV_UNF: cover property (rd_en && empty);
  COV_IRQ: cover property ($rose(irq));
endmodule // crf_fifo_chk

// File: crf_fifo_tb.sv
// Testbench of the FIFO: fill, overflow, interrupt, drain and underflow.
// Assumes dut is single clock, standard read, synchronous reset, protection
// and hold on; dut_ff beside it is a dual clock fall-through build.
`timescale 1ns/1ps
`include "crf_defines.vh"
module crf_fifo_tb;
  localparam DW = 8;
  localparam DEPTH = 8;
  localparam AFO = 2;
  reg core_clk = 1'h0;
  reg reset = 1'h1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  wire wr_en, rd_en, full, almost_full, empty, almost_empty, irq;
  wire [DW-1:0] wr_data, rd_data;
  wire [31:0] reg_rdata_r;
  integer num_errors = 0, checks_done = 0, cyc = 0, i;
  reg [31:0] rv;
  reg [DW-1:0] d;
  // Second build: writer on core_clk, reader on its own unrelated clock
  reg rd_clk2 = 1'h0;
  reg wr_en2 = 1'h0;
  reg rd_en2 = 1'h0;
  reg [DW-1:0] wr_data2 = 8'h0;
  wire empty2;
  wire [DW-1:0] rd_data2;
  always #5 core_clk = ~core_clk;
  always #7 rd_clk2 = ~rd_clk2;
  crf_fifo #(.DATA_W(DW), .DEPTH(DEPTH), .AFULL_OFFSET(AFO), .AEMPTY_OFFSET(AFO),
    .SYNC_RESET(1)) dut (
    .core_clk(core_clk), .reset(reset), .rd_clk(core_clk), .wr_en(wr_en), .wr_data(wr_data),
    .full(full), .almost_full(almost_full), .rd_en(rd_en), .rd_data(rd_data), .empty(empty),
    .almost_empty(almost_empty), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq(irq));
  crf_user #(.DATA_W(DW)) user (.core_clk(core_clk), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data));
  crf_fifo #(.DATA_W(DW), .DEPTH(DEPTH), .AFULL_OFFSET(AFO), .AEMPTY_OFFSET(AFO),
    .DUAL_CLOCK(1), .FWFT(1)) dut_ff (
    .core_clk(core_clk), .reset(reset), .rd_clk(rd_clk2), .wr_en(wr_en2), .wr_data(wr_data2),
    .full(), .almost_full(), .rd_en(rd_en2), .rd_data(rd_data2), .empty(empty2),
    .almost_empty(), .reg_addr(4'h0), .reg_wdata(32'h0), .reg_wr(1'h0), .reg_rd(1'h0),
    .reg_rdata_r(), .irq());
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task reg_write(input [3:0] a, input [31:0] v);
    begin
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'h0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task reg_read(input [3:0] a, output [31:0] v);
    begin
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata_r;
    end
  endtask
  // One read on the second build's read clock
  task pop2;
    begin
      @(posedge rd_clk2);
      rd_en2 <= 1'h1;
      @(posedge rd_clk2);
      rd_en2 <= 1'h0;
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Hang guard: the whole sequence needs about 80 cycles
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    repeat (3) @(posedge core_clk);
    #1 check({empty, almost_empty, full, almost_full, irq}, 5'h18);
    $display("Test reset done");
    user.burst(DEPTH - AFO, 8'h10);
    #1 check({almost_full, full}, 2'h2);
    user.burst(AFO + 1, 8'h16);
    #1 check(full, 1'h1);
    reg_read(`CRF_REG_LEVEL, rv);
    check(rv, (DEPTH << 4) | 3);
    reg_read(`CRF_REG_STATUS, rv);
    check(rv, 32'hd);
    $display("Test fill done");
    reg_write(`CRF_REG_MASK, 32'hf);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'h1);
    reg_write(`CRF_REG_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'h0);
    reg_write(`CRF_REG_MASK, 32'hf);
    reg_write(`CRF_REG_STATUS, 32'hf);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'h0);
    $display("Test interrupt done");
    for (i = 0; i < DEPTH; i = i + 1) begin
      user.pop(d);
      check(d, 8'h10 + i);
    end
    check({empty, almost_empty}, 2'h3);
    user.pop(d);
    repeat (4) @(posedge core_clk);
    #1 check(rd_data, 8'h17);
    reg_read(`CRF_REG_STATUS, rv);
    check(rv, 32'h2);
    $display("Test drain done");
    // Fall-through build: first word shows with no read, later reads as usual
    check({empty2, rd_data2}, 9'h100);
    @(posedge core_clk);
    wr_en2 <= 1'h1;
    wr_data2 <= 8'h5a;
    @(posedge core_clk);
    wr_data2 <= 8'h5b;
    @(posedge core_clk);
    wr_en2 <= 1'h0;
    repeat (12) @(posedge core_clk);
    #1 check({empty2, rd_data2}, 9'h05a);
    pop2;
    check({empty2, rd_data2}, 9'h05b);
    pop2;
    check({empty2, rd_data2}, 9'h15b);
    $display("Test fall-through done");
    end_of_test;
  end
endmodule // crf_fifo_tb
bind crf_fifo crf_fifo_chk #(.DATA_W(DATA_W), .DEPTH(DEPTH), .AFULL_OFFSET(AFULL_OFFSET),
  .AEMPTY_OFFSET(AEMPTY_OFFSET), .DUAL_CLOCK(DUAL_CLOCK), .FWFT(FWFT)) chk (
  .core_clk(core_clk), .reset(reset), .rd_clk(rd_clk),
  .wr_en(wr_en), .wr_data(wr_data), .full(full), .almost_full(almost_full), .rd_en(rd_en),
  .rd_data(rd_data), .empty(empty), .almost_empty(almost_empty), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq(irq));
